// [baud_clock_gen.sv]
`timescale 1ns/1ps

// Function
// - Async normal: bit rate is system clock over sixteen times divisor plus one.
// - Double speed async: divide by eight instead of sixteen.
// - Sync master: bit rate is system clock over two times divisor plus one.
// - Divisor joins high and low registers, accepting zero through 4095.
// - Double speed setting has no effect in synchronous operation.
// - Double speed receiver uses eight samples per bit, not sixteen.
// - Slave external clock passes synchroniser then edge detector before use.
// - Sync pin is clock input in slave, clock output in master.
// - Sync receive samples on the edge opposite to transmit change.
// - Polarity clear: change rising, sample falling; set: the reverse.
// - Down-counter reloads at zero or low-divisor write, pulsing at zero.
// - Mode bit picks async or sync; pin direction picks master or slave.
module baud_clock_gen
#(
    parameter int DIV_WIDTH = baud_pkg::DIV_W
)
(
    input  wire logic        SYS_CLK_I,
    input  wire logic        RST_I,
    // AXI4-Lite slave
    input  wire logic [3:0]  S_AXI_AWADDR_I,
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    output logic [1:0]       S_AXI_BRESP_O,
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    input  wire logic [3:0]  S_AXI_ARADDR_I,
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O,
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    // Transfer clock pin, three signals
    input  wire logic        XFER_CLK_PIN_I,
    output logic             XFER_CLK_PIN_O,
    output logic             XFER_CLK_PIN_OE_O,
    // Strobes to transmitter and receiver
    output logic             TX_CHANGE_O,
    output logic             RX_SAMPLE_O,
    output logic             RX_TICK_O
);

    logic [DIV_WIDTH-1:0]          rate_divisor;
    logic [baud_pkg::DIV_LOW_W-1:0]  rate_divisor_low_reg;
    logic [baud_pkg::DIV_HIGH_W-1:0] rate_divisor_high_reg;
    baud_pkg::clk_ctrl_s           ctrl_reg;
    baud_pkg::clk_mode_e           mode;
    baud_pkg::clk_strobe_s         strobe_next;
    baud_pkg::clk_strobe_s         strobe_reg;
    logic [DIV_WIDTH-1:0]          count_reg;
    logic                          baud_tick;
    logic [3:0]                    ovs_reg;
    logic [3:0]                    ovs_last;
    logic                          ovs_wrap;
    logic                          pin_clk_reg;
    logic                          ext_rise;
    logic                          ext_fall;
    logic                          aw_held_reg;
    logic [3:0]                    aw_addr_reg;
    logic                          w_held_reg;
    logic [31:0]                   w_data_reg;
    logic [3:0]                    w_strb_reg;
    logic                          wr_fire;
    logic                          low_write;
    logic [31:0]                   rd_data;
    logic [1:0]                    rd_resp;

    // Divisor from both registers
    assign rate_divisor = {rate_divisor_high_reg, rate_divisor_low_reg};

    // Mode decode
    always_comb
    begin
        if (ctrl_reg.sync_async_sel)
        begin
            mode = ctrl_reg.xfer_clk_pin_dir ? baud_pkg::MODE_SYNC_MASTER
                                             : baud_pkg::MODE_SYNC_SLAVE;
        end
        else
        begin
            mode = ctrl_reg.double_rate_sel ? baud_pkg::MODE_ASYNC_DOUBLE
                                            : baud_pkg::MODE_ASYNC_NORMAL;
        end
    end

    // Write address channel capture
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
        end
        else if (wr_fire)
        begin
            aw_held_reg <= 1'b0;
        end
        else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)  // Take only on a handshake
        begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR_I;
        end
    end

    // Write data channel capture
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end
        else if (wr_fire)
        begin
            w_held_reg <= 1'b0;
        end
        else if (S_AXI_WVALID_I && S_AXI_WREADY_O)  // Take only on a handshake
        begin
            w_held_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA_I;
            w_strb_reg <= S_AXI_WSTRB_I;
        end
    end

    assign wr_fire   = aw_held_reg && w_held_reg && !S_AXI_BVALID_O;
    assign low_write = wr_fire && (aw_addr_reg == baud_pkg::ADDR_DIV_LOW) && w_strb_reg[0];

    // Ready outputs registered, low while a word is held
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            S_AXI_AWREADY_O <= 1'b0;
            S_AXI_WREADY_O  <= 1'b0;
        end
        else
        begin
            S_AXI_AWREADY_O <= !aw_held_reg && !(S_AXI_AWVALID_I && S_AXI_AWREADY_O);
            S_AXI_WREADY_O  <= !w_held_reg && !(S_AXI_WVALID_I && S_AXI_WREADY_O);
        end
    end

    // Register writes, byte lane zero only carries data
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            rate_divisor_low_reg  <= baud_pkg::DIV_RESET[baud_pkg::DIV_LOW_W-1:0];
            rate_divisor_high_reg <= baud_pkg::DIV_RESET[DIV_WIDTH-1:baud_pkg::DIV_LOW_W];
            ctrl_reg              <= '0;
        end
        else if (wr_fire && w_strb_reg[0])
        begin
            unique case (aw_addr_reg)
                baud_pkg::ADDR_DIV_LOW:
                    rate_divisor_low_reg <= w_data_reg[baud_pkg::DIV_LOW_W-1:0];
                baud_pkg::ADDR_DIV_HIGH:
                    rate_divisor_high_reg <= w_data_reg[baud_pkg::DIV_HIGH_W-1:0];
                baud_pkg::ADDR_CTRL:
                    ctrl_reg <= w_data_reg[baud_pkg::CTRL_W-1:0];
                default:
                    ;
            endcase
        end
    end

    // Write response
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O  <= baud_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O  <= (aw_addr_reg == baud_pkg::ADDR_STAT)
                              || (aw_addr_reg[1:0] != 2'b00) ? baud_pkg::RESP_SLVERR
                                                             : baud_pkg::RESP_OKAY;
        end
        else if (S_AXI_BREADY_I)
        begin
            S_AXI_BVALID_O <= 1'b0;
        end
    end

    // Read decode
    always_comb
    begin
        rd_data = 32'h0000_0000;
        rd_resp = baud_pkg::RESP_OKAY;
        unique case (S_AXI_ARADDR_I)
            baud_pkg::ADDR_DIV_LOW:  rd_data[baud_pkg::DIV_LOW_W-1:0] = rate_divisor_low_reg;
            baud_pkg::ADDR_DIV_HIGH: rd_data[baud_pkg::DIV_HIGH_W-1:0] = rate_divisor_high_reg;
            baud_pkg::ADDR_CTRL:     rd_data[baud_pkg::CTRL_W-1:0] = ctrl_reg;
            baud_pkg::ADDR_STAT:     rd_data[DIV_WIDTH-1:0] = count_reg;
            default:                 rd_resp = baud_pkg::RESP_SLVERR;
        endcase
    end

    // Read channel, one transfer at a time
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O  <= 1'b0;
            S_AXI_RDATA_O   <= 32'h0000_0000;
            S_AXI_RRESP_O   <= baud_pkg::RESP_OKAY;
        end
        else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
        begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O  <= 1'b1;
            S_AXI_RDATA_O   <= rd_data;
            S_AXI_RRESP_O   <= rd_resp;
        end
        else if (S_AXI_RVALID_O)
        begin
            if (S_AXI_RREADY_I)
            begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end
        else
        begin
            S_AXI_ARREADY_O <= 1'b1;
        end
    end

    // Baud down-counter, reload at zero or low write
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            count_reg <= baud_pkg::DIV_RESET;
        end
        else if (low_write)
        begin
            count_reg <= {rate_divisor_high_reg, w_data_reg[baud_pkg::DIV_LOW_W-1:0]};
        end
        else if (count_reg == '0)
        begin
            count_reg <= rate_divisor;
        end
        else
        begin
            count_reg <= count_reg - 1'b1;
        end
    end

    // One pulse per zero, divides by divisor plus one
    assign baud_tick = (count_reg == '0) && !low_write;

    // Samples per bit: sixteen normal, eight double; sync modes take the sixteen default
    always_comb
    begin
        unique case (mode)
            baud_pkg::MODE_ASYNC_DOUBLE: ovs_last = baud_pkg::OVS_DOUBLE_LAST;
            default:                     ovs_last = baud_pkg::OVS_NORMAL_LAST;
        endcase
    end

    // Oversample counter, wraps once per bit in async modes
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            ovs_reg <= 4'h0;
        end
        else if (ctrl_reg.sync_async_sel)
        begin
            ovs_reg <= 4'h0;
        end
        else if (baud_tick)
        begin
            ovs_reg <= (ovs_reg >= ovs_last) ? 4'h0 : ovs_reg + 4'h1;
        end
    end

    assign ovs_wrap = baud_tick && (ovs_reg >= ovs_last);

    // Master toggles the pin clock on each tick: divide by two
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            pin_clk_reg <= 1'b0;
        end
        else if (mode == baud_pkg::MODE_SYNC_MASTER)
        begin
            if (baud_tick)
            begin
                pin_clk_reg <= ~pin_clk_reg;
            end
        end
        else
        begin
            pin_clk_reg <= ctrl_reg.xfer_clk_polarity;
        end
    end

    // Slave clock input path; far side keeps it below a quarter rate
    xfer_clk_sync u_sync
    (
        .sys_clk_i (SYS_CLK_I),
        .rst_i     (RST_I),
        .pin_i     (XFER_CLK_PIN_I),
        .rise_o    (ext_rise),
        .fall_o    (ext_fall)
    );

    // Strobe selection per mode and polarity
    always_comb
    begin
        strobe_next = '0;
        unique case (mode)
            baud_pkg::MODE_ASYNC_NORMAL, baud_pkg::MODE_ASYNC_DOUBLE:
            begin
                strobe_next.rx_tick   = baud_tick;
                strobe_next.tx_change = ovs_wrap;
            end
            baud_pkg::MODE_SYNC_MASTER:
            begin
                strobe_next.rx_tick = baud_tick;
                // Leaving the polarity level is the change edge
                strobe_next.tx_change = baud_tick && (pin_clk_reg == ctrl_reg.xfer_clk_polarity);
                strobe_next.rx_sample = baud_tick && (pin_clk_reg != ctrl_reg.xfer_clk_polarity);
            end
            baud_pkg::MODE_SYNC_SLAVE:
            begin
                strobe_next.tx_change = ctrl_reg.xfer_clk_polarity ? ext_fall : ext_rise;
                strobe_next.rx_sample = ctrl_reg.xfer_clk_polarity ? ext_rise : ext_fall;
            end
        endcase
    end

    // Registered strobes and pin drive
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            strobe_reg        <= '0;
            XFER_CLK_PIN_OE_O <= 1'b0;
        end
        else
        begin
            strobe_reg        <= strobe_next;
            XFER_CLK_PIN_OE_O <= (mode == baud_pkg::MODE_SYNC_MASTER);
        end
    end

    // Pin straight from the toggle flop, so its edge lines up with the strobe
    assign XFER_CLK_PIN_O = pin_clk_reg;
    assign TX_CHANGE_O = strobe_reg.tx_change;
    assign RX_SAMPLE_O = strobe_reg.rx_sample;
    assign RX_TICK_O   = strobe_reg.rx_tick;

endmodule

// [baud_clock_gen_monitor.sv]
`timescale 1ns/1ps

// Port-level checks of the baud and transfer clock generator
module baud_clock_gen_monitor
(
    input wire logic        SYS_CLK_I,
    input wire logic        RST_I,
    input wire logic        S_AXI_AWVALID_I,
    input wire logic        S_AXI_AWREADY_O,
    input wire logic        S_AXI_WVALID_I,
    input wire logic        S_AXI_WREADY_O,
    input wire logic [1:0]  S_AXI_BRESP_O,
    input wire logic        S_AXI_BVALID_O,
    input wire logic        S_AXI_BREADY_I,
    input wire logic [3:0]  S_AXI_ARADDR_I,
    input wire logic        S_AXI_ARVALID_I,
    input wire logic        S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic [1:0]  S_AXI_RRESP_O,
    input wire logic        S_AXI_RVALID_O,
    input wire logic        XFER_CLK_PIN_I,
    input wire logic        XFER_CLK_PIN_O,
    input wire logic        XFER_CLK_PIN_OE_O,
    input wire logic        TX_CHANGE_O,
    input wire logic        RX_SAMPLE_O
);
    logic pin_d_reg;
    logic pin_edge;

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    // Previous pin level, for spotting external clock edges
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
            pin_d_reg <= 1'b0;
        else
            pin_d_reg <= XFER_CLK_PIN_I;
    end
    assign pin_edge = XFER_CLK_PIN_I ^ pin_d_reg;

    wr_answer_a: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
        && S_AXI_WREADY_O |-> ##2 S_AXI_BVALID_O) else $error("write answer late");
    bresp_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O
        && $stable(S_AXI_BRESP_O)) else $error("write answer dropped");
    rd_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
        else $error("read answer late");
    rd_error_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I[1:0] != 2'h0
        |=> S_AXI_RRESP_O == baud_pkg::RESP_SLVERR && S_AXI_RDATA_O == 32'h0000_0000)
        else $error("unaligned read not refused");
    ar_block_a: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
        else $error("read taken while answer pending");
    edge_split_a: assert property (!(TX_CHANGE_O && RX_SAMPLE_O))
        else $error("change and sample on one edge");
    master_edge_a: assert property (XFER_CLK_PIN_OE_O && $past(XFER_CLK_PIN_OE_O)
        && $changed(XFER_CLK_PIN_O) |-> TX_CHANGE_O || RX_SAMPLE_O)
        else $error("master pin edge without strobe");
    slave_delay_a: assert property (RX_SAMPLE_O && !XFER_CLK_PIN_OE_O
        |-> $past(pin_edge, 3) || $past(pin_edge, 4)) else $error("slave sample not synchronised");
    tx_pulse_a: assert property (TX_CHANGE_O |=> !TX_CHANGE_O)
        else $error("change strobe longer than one cycle");

    master_c: cover property (XFER_CLK_PIN_OE_O && TX_CHANGE_O);
    slave_c: cover property (!XFER_CLK_PIN_OE_O && RX_SAMPLE_O);
    wr_error_c: cover property (S_AXI_BVALID_O && S_AXI_BRESP_O == baud_pkg::RESP_SLVERR);
endmodule

// [baud_pkg.sv]
package baud_pkg;

    // Register byte addresses on the AXI4-Lite slave
    localparam logic [3:0]  ADDR_DIV_LOW   = 4'h0;
    localparam logic [3:0]  ADDR_DIV_HIGH  = 4'h4;
    localparam logic [3:0]  ADDR_CTRL      = 4'h8;
    localparam logic [3:0]  ADDR_STAT      = 4'hC;

    // Divisor layout
    localparam int          DIV_W          = 12;
    localparam int          DIV_LOW_W      = 8;
    localparam int          DIV_HIGH_W     = 4;
    localparam logic [11:0] DIV_RESET      = 12'h000;

    // Control bit positions
    localparam int          CTRL_DOUBLE    = 0;
    localparam int          CTRL_SYNC      = 1;
    localparam int          CTRL_PIN_DIR   = 2;
    localparam int          CTRL_POLARITY  = 3;
    localparam int          CTRL_W         = 4;

    // Oversampling counts per bit
    localparam logic [3:0]  OVS_NORMAL_LAST = 4'hF;
    localparam logic [3:0]  OVS_DOUBLE_LAST = 4'h7;

    // AXI response codes
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;

    // Clock operating modes
    typedef enum logic [1:0] {
        MODE_ASYNC_NORMAL = 2'b00,
        MODE_ASYNC_DOUBLE = 2'b01,
        MODE_SYNC_MASTER  = 2'b11,
        MODE_SYNC_SLAVE   = 2'b10
    } clk_mode_e;

    // Control settings carried together
    typedef struct packed {
        logic xfer_clk_polarity;
        logic xfer_clk_pin_dir;
        logic sync_async_sel;
        logic double_rate_sel;
    } clk_ctrl_s;

    // Clock strobes handed to the data paths
    typedef struct packed {
        logic tx_change;
        logic rx_sample;
        logic rx_tick;
    } clk_strobe_s;

endpackage

// [serial_baud_and_sync_clock_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end

module serial_baud_and_sync_clock_tb;
    logic        sys_clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, rdv;
    logic [1:0]  bresp, rresp, rs;
    logic        awready, wready, bvalid, arready, rvalid, pin_o, pin_oe, pin_w;
    logic        tx_change, rx_sample, rx_tick, st_pin, st_run, st_idle;
    int          errors, n_tests, p;

    // Pin level from the design and the remote station
    assign pin_w = pin_oe ? pin_o : st_pin;

    baud_clock_gen u_dut (.SYS_CLK_I(sys_clk), .RST_I(rst), .S_AXI_AWADDR_I(awaddr),
        .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
        .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
        .S_AXI_RREADY_I(rready), .XFER_CLK_PIN_I(pin_w), .XFER_CLK_PIN_O(pin_o),
        .XFER_CLK_PIN_OE_O(pin_oe), .TX_CHANGE_O(tx_change), .RX_SAMPLE_O(rx_sample),
        .RX_TICK_O(rx_tick));

    xfer_clk_station u_station (.sys_clk_i(sys_clk), .run_i(st_run), .idle_i(st_idle),
        .half_i(8'h06), .pin_o(st_pin));

    // System clock, 100 MHz
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Register write: address and data offered together
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_hs, w_hs, b_hs;
        int   t;
        t = 0;
        b_hs = 1'b0;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_hs && t < 200)
        begin
            @(negedge sys_clk);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bvalid;
            r = bresp;
            @(posedge sys_clk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            t++;
        end
        bready <= 1'b0;
        if (!b_hs) errors++;
    endtask

    // Register read
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hs, r_hs;
        int   t;
        t = 0;
        r_hs = 1'b0;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_hs && t < 200)
        begin
            @(negedge sys_clk);
            ar_hs = arvalid && arready;
            r_hs = rvalid;
            d = rdata;
            r = rresp;
            @(posedge sys_clk);
            if (ar_hs) arvalid <= 1'b0;
            t++;
        end
        rready <= 1'b0;
        if (!r_hs) errors++;
    endtask

    function automatic logic pulse(input int s);
        return (s == 0) ? tx_change : (s == 1) ? rx_tick : rx_sample;
    endfunction

    // Cycles between two consecutive pulses of one strobe
    task automatic period(input int s, output int n);
        int t;
        t = 0;
        n = 0;
        do @(negedge sys_clk); while (!pulse(s) && ++t < 9000);
        do begin @(negedge sys_clk); n++; end while (!pulse(s) && n < 9000);
    endtask

    // Select a clock mode, then check bit period, pin direction and edge use
    task automatic mode(input logic [3:0] c, input int exp);
        baud_pkg::clk_ctrl_s m;
        m = c;
        st_idle <= m.xfer_clk_polarity;
        axi_wr(baud_pkg::ADDR_CTRL, {28'h000_0000, c}, rs);
        st_run <= m.sync_async_sel && !m.xfer_clk_pin_dir;
        repeat (8) @(posedge sys_clk);  // Let strobes from the old pin level drain
        period(0, p);
        `CHK("bit period", exp, p)
        `CHK("pin enable", m.sync_async_sel & m.xfer_clk_pin_dir, pin_oe)
        if (m.sync_async_sel)
        begin
            `CHK("change level", ~m.xfer_clk_polarity, pin_w)
            period(2, p);
            `CHK("sample level", m.xfer_clk_polarity, pin_w)
        end
        @(posedge sys_clk);
        st_run <= 1'b0;
    endtask

    task automatic results();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        {rst, errors, n_tests} = {1'b1, 64'h0};
        {awvalid, wvalid, bready, arvalid, rready, st_run, st_idle} = 7'h00;
        {awaddr, araddr, wstrb, wdata} = {12'h00F, 32'h0000_0000};
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 3; i++)
        begin
            axi_rd(4'(i * 4), rdv, rs);
            `CHK("reset value", 32'h0000_0000, rdv)
        end
        axi_rd(4'h2, rdv, rs);
        `CHK("unaligned read", baud_pkg::RESP_SLVERR, rs)
        axi_wr(baud_pkg::ADDR_STAT, 32'h0000_0001, rs);
        `CHK("status write", baud_pkg::RESP_SLVERR, rs)
        axi_wr(baud_pkg::ADDR_DIV_HIGH, 32'hFFFF_FFFF, rs);
        axi_wr(baud_pkg::ADDR_DIV_LOW, 32'h0000_00FF, rs);
        axi_rd(baud_pkg::ADDR_DIV_HIGH, rdv, rs);
        `CHK("divisor high", 32'h0000_000F, rdv)
        period(1, p);
        `CHK("max tick period", 4096, p)
        axi_wr(baud_pkg::ADDR_DIV_HIGH, 32'h0000_0000, rs);
        axi_wr(baud_pkg::ADDR_DIV_LOW, 32'h0000_0003, rs);
        period(1, p);
        `CHK("tick period", 4, p)
        mode(4'h0, 16 * 4);
        mode(4'h6, 2 * 4);
        mode(4'h1, 8 * 4);
        mode(4'hE, 2 * 4);
        mode(4'h2, 12);
        mode(4'h7, 2 * 4);
        mode(4'hA, 12);
        results();
    end

    // Watchdog against a hang
    initial
    begin
        #400000;
        errors++;
        results();
    end
endmodule

bind baud_clock_gen baud_clock_gen_monitor u_mon (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I),
    .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
    .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
    .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
    .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
    .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
    .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
    .S_AXI_RVALID_O(S_AXI_RVALID_O), .XFER_CLK_PIN_I(XFER_CLK_PIN_I),
    .XFER_CLK_PIN_O(XFER_CLK_PIN_O), .XFER_CLK_PIN_OE_O(XFER_CLK_PIN_OE_O),
    .TX_CHANGE_O(TX_CHANGE_O), .RX_SAMPLE_O(RX_SAMPLE_O));

// [xfer_clk_station.sv]
`timescale 1ns/1ps

// Remote station supplying the transfer clock in synchronous slave operation
module xfer_clk_station
(
    input  wire logic       sys_clk_i,
    input  wire logic       run_i,
    input  wire logic       idle_i,
    input  wire logic [7:0] half_i,
    output logic            pin_o
);
    logic [7:0] cnt_reg;
    logic [7:0] half_lim;

    // Never faster than a sixth of the system clock
    assign half_lim = (half_i < 8'h03) ? 8'h03 : half_i;

    // Clock stands still at its idle level outside frames
    always_ff @(posedge sys_clk_i)
    begin
        if (!run_i)
        begin
            pin_o   <= idle_i;
            cnt_reg <= 8'h00;
        end
        else if (cnt_reg == half_lim - 8'h01)
        begin
            pin_o   <= ~pin_o;
            cnt_reg <= 8'h00;
        end
        else
            cnt_reg <= cnt_reg + 8'h01;
    end
endmodule

// [xfer_clk_sync.sv]
`timescale 1ns/1ps

// Synchroniser and edge detector for the external transfer clock
module xfer_clk_sync
(
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      rise_o,
    output logic      fall_o
);

    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // Two stages, then one more for edge history
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // Edge detection on the synchronised level only
    assign rise_o = sync_reg & ~last_reg;
    assign fall_o = ~sync_reg & last_reg;

endmodule
